/* File: verilog/tbp_pkg.sv */
// Package for the timer based PWM output block: register map, fields, resets.
// Assumes a 32-bit APB bus with word-aligned registers.
package tbp_pkg;
    localparam logic [7:0] TBP_OFS_CTRL1 = 8'h00;
    localparam logic [7:0] TBP_OFS_CTRL2 = 8'h04;
    localparam logic [7:0] TBP_OFS_DUTY_LOW1 = 8'h08;
    localparam logic [7:0] TBP_OFS_DUTY_LOW2 = 8'h0c;
    localparam logic [7:0] TBP_OFS_SHADOW1 = 8'h10;
    localparam logic [7:0] TBP_OFS_SHADOW2 = 8'h14;
    localparam logic [7:0] TBP_OFS_PERIOD = 8'h18;
    localparam logic [7:0] TBP_OFS_TCTRL = 8'h1c;
    localparam logic [7:0] TBP_OFS_TCOUNT = 8'h20;
    localparam logic [7:0] TBP_OFS_DIR = 8'h24;
    localparam logic [7:0] TBP_OFS_PORT = 8'h28;
    localparam logic [7:0] TBP_OFS_IRQ_STAT = 8'h2c;
    localparam logic [7:0] TBP_OFS_IRQ_EN = 8'h30;
    localparam logic [7:0] TBP_OFS_IRQ_CLR = 8'h34;
    localparam logic [7:0] TBP_OFS_SLEEP = 8'h38;
    localparam logic [7:0] TBP_RST_CTRL = 8'h00;
    localparam logic [7:0] TBP_RST_PERIOD = 8'hff;
    localparam logic [7:0] TBP_RST_TCTRL = 8'h00;
    localparam logic [7:0] TBP_RST_TCOUNT = 8'h00;
    localparam logic [1:0] TBP_RST_DIR = 2'h3;
    localparam int TBP_CTRL_MODE_LSB = 0;
    localparam int TBP_CTRL_DLB_LSB = 4;
    localparam int TBP_TCTRL_PS_LSB = 0;
    localparam int TBP_TCTRL_RUN = 2;
    localparam logic [3:0] TBP_MODE_PWM = 4'hc;
    localparam logic [1:0] TBP_PS_DIV1 = 2'h0;
    localparam logic [1:0] TBP_PS_DIV4 = 2'h1;
    localparam int TBP_IRQ_MATCH = 0;
    localparam int TBP_IRQ_PWM1 = 1;
    localparam int TBP_IRQ_PWM2 = 2;
    localparam int TBP_IRQ_W = 3;
endpackage : tbp_pkg

/* File: verilog/tbp_regfile.sv */
// Small register memory holding the two duty words; read data is registered.
// Assumes one write and one read port on the core clock.
`timescale 1ns/100ps
module tbp_regfile #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic i_core_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    initial begin
        if (DEPTH < 2) $error("tbp_regfile depth below 2");
    end

    always_ff @(posedge i_core_clk) begin
        if (i_ce && i_we) begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            o_rdata <= mem_ff[i_raddr];
        end
    end
endmodule : tbp_regfile

/* File: verilog/tbp_pwm.sv */
// Two-channel PWM generator driven by a shared 8-bit period timer, APB slave.
// Assumes one core clock; i_sleep freezes the engine, i_ce freezes everything.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module tbp_pwm
    import tbp_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sleep,
    output logic [1:0] o_pin_out,
    output logic [1:0] o_pin_oe,
    output logic o_irq
);
    initial begin
        if (CHANNELS != 2) $error("tbp_pwm supports exactly two channels");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [7:0] ctrl_ff [2];
    logic [7:0] duty_low_ff [2];
    logic [7:0] shadow_ff [2];
    logic [1:0] latch_ff [2];
    logic [7:0] period_ff;
    logic [7:0] tctrl_ff;
    logic [7:0] tcount_ff;
    logic [5:0] presc_ff;
    logic [1:0] dir_ff;
    logic [1:0] port_ff;
    logic [TBP_IRQ_W-1:0] irq_stat_ff;
    logic [TBP_IRQ_W-1:0] irq_en_ff;
    logic [1:0] pwm_lvl_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    function automatic logic is_pwm(input logic [7:0] ctrl);
        is_pwm = (ctrl[TBP_CTRL_MODE_LSB+:4] & TBP_MODE_PWM) == TBP_MODE_PWM;
    endfunction : is_pwm

    function automatic logic [9:0] duty_word(input logic [7:0] hi, input logic [1:0] lo);
        duty_word = {hi, lo};
    endfunction : duty_word

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode. Access phase takes two cycles, as pready is registered.
    logic apb_acc;
    logic apb_wr;
    logic run_eng;
    assign apb_acc = i_psel && i_penable && !pready_ff;
    assign apb_wr = apb_acc && i_pwrite && i_pstrb[0];
    assign run_eng = i_ce && !i_sleep;

    logic known;
    always_comb begin
        known = 1'b1;
        if (i_paddr == TBP_OFS_CTRL1) known = 1'b1;
        else if (i_paddr == TBP_OFS_CTRL2) known = 1'b1;
        else if (i_paddr == TBP_OFS_DUTY_LOW1) known = 1'b1;
        else if (i_paddr == TBP_OFS_DUTY_LOW2) known = 1'b1;
        else if (i_paddr == TBP_OFS_SHADOW1) known = 1'b1;
        else if (i_paddr == TBP_OFS_SHADOW2) known = 1'b1;
        else if (i_paddr == TBP_OFS_PERIOD) known = 1'b1;
        else if (i_paddr == TBP_OFS_TCTRL) known = 1'b1;
        else if (i_paddr == TBP_OFS_TCOUNT) known = 1'b1;
        else if (i_paddr == TBP_OFS_DIR) known = 1'b1;
        else if (i_paddr == TBP_OFS_PORT) known = 1'b1;
        else if (i_paddr == TBP_OFS_IRQ_STAT) known = 1'b1;
        else if (i_paddr == TBP_OFS_IRQ_EN) known = 1'b1;
        else if (i_paddr == TBP_OFS_IRQ_CLR) known = 1'b1;
        else if (i_paddr == TBP_OFS_SLEEP) known = 1'b1;
        else known = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Time base.
    logic [1:0] low_bits;
    logic tick;
    logic period_end;
    always_comb begin
        if (tctrl_ff[TBP_TCTRL_PS_LSB+:2] == TBP_PS_DIV1) begin
            low_bits = presc_ff[1:0];
            tick = presc_ff[1:0] == 2'h3;
        end else if (tctrl_ff[TBP_TCTRL_PS_LSB+:2] == TBP_PS_DIV4) begin
            low_bits = presc_ff[3:2];
            tick = presc_ff[3:0] == 4'hf;
        end else begin
            low_bits = presc_ff[5:4];
            tick = presc_ff == 6'h3f;
        end
    end
    logic [9:0] time_base;
    assign time_base = {tcount_ff, low_bits};
    assign period_end = tick && (tcount_ff == period_ff);

    logic timer_on;
    assign timer_on = tctrl_ff[TBP_TCTRL_RUN];

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            presc_ff <= 6'h00;
        end else if (run_eng && timer_on) begin
            presc_ff <= presc_ff + 6'h01;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            tcount_ff <= TBP_RST_TCOUNT;
        end else if (i_ce) begin
            if (apb_wr && i_paddr == TBP_OFS_TCOUNT) begin
                tcount_ff <= i_pwdata[7:0];
            end else if (run_eng && timer_on && tick) begin
                tcount_ff <= period_end ? 8'h00 : tcount_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel control, duty buffering and output level.
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [7:0] ofs_ctrl;
        logic [7:0] ofs_low;
        logic [7:0] ofs_sh;
        assign ofs_ctrl = c == 0 ? TBP_OFS_CTRL1 : TBP_OFS_CTRL2;
        assign ofs_low = c == 0 ? TBP_OFS_DUTY_LOW1 : TBP_OFS_DUTY_LOW2;
        assign ofs_sh = c == 0 ? TBP_OFS_SHADOW1 : TBP_OFS_SHADOW2;

        always_ff @(posedge i_core_clk) begin
            if (!i_rstn) begin
                ctrl_ff[c] <= TBP_RST_CTRL;
            end else if (i_ce && apb_wr && i_paddr == ofs_ctrl) begin
                ctrl_ff[c] <= {2'b00, i_pwdata[5:0]};
            end
        end

        always_ff @(posedge i_core_clk) begin
            if (!i_rstn) begin
                duty_low_ff[c] <= 8'h00;
            end else if (i_ce && apb_wr && i_paddr == ofs_low) begin
                duty_low_ff[c] <= i_pwdata[7:0];
            end
        end

        always_ff @(posedge i_core_clk) begin
            if (!i_rstn) begin
                shadow_ff[c] <= 8'h00;
                latch_ff[c] <= 2'h0;
            end else if (i_ce) begin
                if (run_eng && timer_on && period_end && is_pwm(ctrl_ff[c])) begin
                    shadow_ff[c] <= duty_low_ff[c];
                    latch_ff[c] <= ctrl_ff[c][TBP_CTRL_DLB_LSB+:2];
                end else if (apb_wr && i_paddr == ofs_sh && !is_pwm(ctrl_ff[c])) begin
                    shadow_ff[c] <= i_pwdata[7:0];
                end
            end
        end

        logic [9:0] next_duty;
        logic duty_hit;
        assign next_duty = duty_word(duty_low_ff[c], ctrl_ff[c][TBP_CTRL_DLB_LSB+:2]);
        // The pin must already be low while the time base equals the duty, or every
        // pulse would be one clock too long.
        assign duty_hit = time_base == duty_word(shadow_ff[c], latch_ff[c]);

        always_ff @(posedge i_core_clk) begin
            if (!i_rstn) begin
                pwm_lvl_ff[c] <= 1'b0;
            end else if (run_eng && timer_on && is_pwm(ctrl_ff[c])) begin
                if (period_end) begin
                    pwm_lvl_ff[c] <= next_duty != 10'h000;
                end else if (duty_hit) begin
                    pwm_lvl_ff[c] <= 1'b0;
                end
            end
        end

        always_ff @(posedge i_core_clk) begin
            if (!i_rstn) begin
                o_pin_out[c] <= 1'b0;
                o_pin_oe[c] <= 1'b0;
            end else if (i_ce) begin
                o_pin_out[c] <= is_pwm(ctrl_ff[c]) ? pwm_lvl_ff[c] && !duty_hit : port_ff[c];
                o_pin_oe[c] <= !dir_ff[c];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer, pin direction and port registers.
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            period_ff <= TBP_RST_PERIOD;
            tctrl_ff <= TBP_RST_TCTRL;
            dir_ff <= TBP_RST_DIR;
            port_ff <= 2'h0;
        end else if (i_ce && apb_wr) begin
            if (i_paddr == TBP_OFS_PERIOD) period_ff <= i_pwdata[7:0];
            else if (i_paddr == TBP_OFS_TCTRL) tctrl_ff <= {1'b0, i_pwdata[6:0]};
            else if (i_paddr == TBP_OFS_DIR) dir_ff <= i_pwdata[1:0];
            else if (i_paddr == TBP_OFS_PORT) port_ff <= i_pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over clear.
    logic [TBP_IRQ_W-1:0] irq_set;
    logic [TBP_IRQ_W-1:0] irq_clr;
    assign irq_set = (run_eng && timer_on && period_end) ? 3'h7 : 3'h0;
    assign irq_clr = (apb_wr && i_paddr == TBP_OFS_IRQ_CLR) ? i_pwdata[2:0] : 3'h0;

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            irq_stat_ff <= 3'h0;
            irq_en_ff <= 3'h0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            if (apb_wr && i_paddr == TBP_OFS_IRQ_EN) irq_en_ff <= i_pwdata[2:0];
            o_irq <= |(irq_stat_ff & irq_en_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB read path.
    // The duty words are mirrored in a small memory for read back; its read data
    // is loaded during the setup cycle, so it is ready at the access edge.
    logic rf_we;
    logic rf_waddr;
    logic rf_raddr;
    logic [7:0] rf_rdata;
    assign rf_we = apb_wr && (i_paddr == TBP_OFS_DUTY_LOW1 || i_paddr == TBP_OFS_DUTY_LOW2);
    assign rf_waddr = i_paddr == TBP_OFS_DUTY_LOW2;
    assign rf_raddr = i_paddr == TBP_OFS_DUTY_LOW2;

    tbp_regfile #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_duty_mirror (
        .i_core_clk(i_core_clk),
        .i_ce(i_ce),
        .i_we(rf_we),
        .i_waddr(rf_waddr),
        .i_wdata(i_pwdata[7:0]),
        .i_raddr(rf_raddr),
        .o_rdata(rf_rdata)
    );

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (i_paddr == TBP_OFS_CTRL1) rd_mux = {24'h0, ctrl_ff[0]};
        else if (i_paddr == TBP_OFS_CTRL2) rd_mux = {24'h0, ctrl_ff[1]};
        else if (i_paddr == TBP_OFS_DUTY_LOW1) rd_mux = {24'h0, rf_rdata};
        else if (i_paddr == TBP_OFS_DUTY_LOW2) rd_mux = {24'h0, rf_rdata};
        else if (i_paddr == TBP_OFS_SHADOW1) rd_mux = {24'h0, shadow_ff[0]};
        else if (i_paddr == TBP_OFS_SHADOW2) rd_mux = {24'h0, shadow_ff[1]};
        else if (i_paddr == TBP_OFS_PERIOD) rd_mux = {24'h0, period_ff};
        else if (i_paddr == TBP_OFS_TCTRL) rd_mux = {24'h0, tctrl_ff};
        else if (i_paddr == TBP_OFS_TCOUNT) rd_mux = {24'h0, tcount_ff};
        else if (i_paddr == TBP_OFS_DIR) rd_mux = {30'h0, dir_ff};
        else if (i_paddr == TBP_OFS_PORT) rd_mux = {30'h0, pwm_lvl_ff};
        else if (i_paddr == TBP_OFS_IRQ_STAT) rd_mux = {29'h0, irq_stat_ff};
        else if (i_paddr == TBP_OFS_IRQ_EN) rd_mux = {29'h0, irq_en_ff};
        else if (i_paddr == TBP_OFS_SLEEP) rd_mux = {31'h0, i_sleep};
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (i_ce) begin
            pready_ff <= apb_acc;
            pslverr_ff <= apb_acc && !known;
            if (apb_acc && !i_pwrite) prdata_ff <= rd_mux;
        end
    end

    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_prdata = prdata_ff;
endmodule : tbp_pwm

/* File: dv/tbp_pwm_properties.sv */
// Port-level timing properties of the timer based PWM block.
// Assumes it is bound to tbp_pwm and sees only that module's ports.
`timescale 1ns/100ps
module tbp_pwm_chk (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_sleep,
    input wire logic [1:0] o_pin_out,
    input wire logic [1:0] o_pin_oe,
    input wire logic o_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    ////////////////////////////////////////////////////////////////////////////////
    pready_wait_a: assert property (i_ce && i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready did not follow the access phase");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready held longer than one cycle");
    pready_cause_a: assert property ($rose(o_pready) |-> $past(i_psel) && $past(i_penable))
        else $error("pready raised without an access phase");
    slverr_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr raised without pready");
    slverr_addr_a: assert property (o_pslverr |->
        $past(i_paddr) > 8'h38 || ($past(i_paddr) & 8'h03) != 8'h00)
        else $error("pslverr on a mapped address");
    rdata_hold_a: assert property (!(i_psel && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data changed without a read");
    reset_release_a: assert property ($rose(i_rstn) |-> o_pin_oe == 2'h0 && !o_irq)
        else $error("pins driven or interrupt high after reset");
    sleep_freeze_a: assert property (i_sleep [*3] |=> $stable(o_pin_out))
        else $error("pin level changed during sleep");
endmodule : tbp_pwm_chk

/* File: dv/tb_timer_based_pwm_output.sv */
// Self-checking testbench for tbp_pwm: register, interrupt and waveform checks.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/100ps
module tb_timer_based_pwm_output;
    import tbp_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic i_sleep = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_irq;
    logic [1:0] o_pin_out, o_pin_oe;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int checked = 0;

    always #4 i_core_clk = ~i_core_clk;

    tbp_pwm dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(4'hf), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_sleep(i_sleep), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        for (k = 0; k < 20 && o_pready !== 1'b1; k++) @(posedge i_core_clk);
        if (o_pready !== 1'b1) begin
            n_fail++;
            results();
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(w, e, rd);
    endtask : rdc

    task automatic waitpin(input logic v, output int n);
        n = 0;
        while (o_pin_out[0] !== v) begin
            @(negedge i_core_clk);
            n++;
            if (n > 3000) begin
                n_fail++;
                results();
            end
        end
    endtask : waitpin

    task automatic hold(input int c, output int ones);
        ones = 0;
        repeat (c) begin
            @(negedge i_core_clk);
            ones += int'(o_pin_out[0] === 1'b1);
        end
    endtask : hold

    // Stops the timer so the match wait below really waits for a fresh period end.
    task automatic setup(input logic [1:0] ps, input logic [7:0] dl, input logic [1:0] db);
        int k;
        apb(1'b1, TBP_OFS_DIR, 32'h3);
        apb(1'b1, TBP_OFS_TCTRL, 32'h0);
        apb(1'b1, TBP_OFS_TCOUNT, 32'h0);
        apb(1'b1, TBP_OFS_PERIOD, 32'h3);
        apb(1'b1, TBP_OFS_CTRL1, {26'h0, db, TBP_MODE_PWM});
        apb(1'b1, TBP_OFS_DUTY_LOW1, {24'h0, dl});
        apb(1'b1, TBP_OFS_IRQ_EN, 32'h1);
        apb(1'b1, TBP_OFS_IRQ_CLR, 32'h7);
        apb(1'b1, TBP_OFS_TCTRL, {29'h0, 1'b1, ps});
        for (k = 0; k < 300 && o_irq !== 1'b1; k++) @(posedge i_core_clk);
        chk("match irq", 32'h1, {31'h0, o_irq});
        if (o_irq !== 1'b1) results();
        apb(1'b1, TBP_OFS_DIR, 32'h0);
    endtask : setup

    ////////////////////////////////////////////////////////////////////////////////
    task automatic regs_reset();
        chk("oe at reset", 32'h0, {30'h0, o_pin_oe});
        rdc("ctrl1", TBP_OFS_CTRL1, 32'h0);
        rdc("ctrl2", TBP_OFS_CTRL2, 32'h0);
        rdc("period", TBP_OFS_PERIOD, 32'hff);
        rdc("tctrl", TBP_OFS_TCTRL, 32'h0);
        rdc("count", TBP_OFS_TCOUNT, 32'h0);
        rdc("dir", TBP_OFS_DIR, 32'h3);
        rdc("status", TBP_OFS_IRQ_STAT, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
    endtask : regs_reset

    // Duty 6 proves the low time-base bits come from the clock phase at divide by one.
    task automatic pwm_timing();
        int n, hi, lo;
        for (int i = 0; i < 3; i++) begin
            setup(i[1:0], 8'h01, 2'h2);
            waitpin(1'b0, n);
            waitpin(1'b1, n);
            waitpin(1'b0, hi);
            waitpin(1'b1, lo);
            chk("high time", 32'(6 << (2 * i)), 32'(hi));
            chk("period", 32'(16 << (2 * i)), 32'(hi + lo));
        end
    endtask : pwm_timing

    task automatic edge_duty();
        int n;
        setup(2'h0, 8'h00, 2'h0);
        hold(20, n);
        hold(40, n);
        chk("zero duty high", 32'h0, 32'(n));
        setup(2'h0, 8'hff, 2'h3);
        hold(20, n);
        hold(40, n);
        chk("long duty high", 32'h28, 32'(n));
    endtask : edge_duty

    task automatic shadow_ro();
        rdc("shadow", TBP_OFS_SHADOW1, 32'hff);
        rdc("duty low", TBP_OFS_DUTY_LOW1, 32'hff);
        apb(1'b1, TBP_OFS_SHADOW1, 32'h12);
        rdc("shadow ro", TBP_OFS_SHADOW1, 32'hff);
    endtask : shadow_ro

    task automatic sleep_hold();
        logic [7:0] c1;
        logic p1;
        apb(1'b1, TBP_OFS_PERIOD, 32'hff);
        repeat (30) @(posedge i_core_clk);
        i_sleep <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        apb(1'b0, TBP_OFS_TCOUNT, 32'h0);
        c1 = rd[7:0];
        p1 = o_pin_out[0];
        repeat (50) @(posedge i_core_clk);
        rdc("sleep count", TBP_OFS_TCOUNT, {24'h0, c1});
        chk("sleep pin", {31'h0, p1}, {31'h0, o_pin_out[0]});
        i_sleep <= 1'b0;
        apb(1'b0, TBP_OFS_TCOUNT, 32'h0);
        chk("wake count", 32'h1, 32'(rd[7:0] == c1 || rd[7:0] == 8'(c1 + 1)));
    endtask : sleep_hold

    task automatic irq_mask();
        apb(1'b1, TBP_OFS_TCTRL, 32'h0);
        repeat (2) @(posedge i_core_clk);
        chk("irq on", 32'h1, {31'h0, o_irq});
        apb(1'b1, TBP_OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge i_core_clk);
        chk("irq masked", 32'h0, {31'h0, o_irq});
        apb(1'b1, TBP_OFS_IRQ_EN, 32'h1);
        apb(1'b1, TBP_OFS_IRQ_CLR, 32'h7);
        rdc("status cleared", TBP_OFS_IRQ_STAT, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, o_irq});
    endtask : irq_mask

    task automatic port_mode();
        apb(1'b1, TBP_OFS_CTRL1, 32'h0);
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, TBP_OFS_PORT, 32'(3 * v));
            repeat (2) @(posedge i_core_clk);
            chk("port pins", 32'(3 * v), {30'h0, o_pin_out});
        end
        chk("pins driven", 32'h3, {30'h0, o_pin_oe});
    endtask : port_mode

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        regs_reset();
        pwm_timing();
        edge_duty();
        shadow_ro();
        sleep_hold();
        irq_mask();
        port_mode();
        results();
    end
endmodule : tb_timer_based_pwm_output

bind tbp_pwm tbp_pwm_chk chk_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
